// ---- hdl/pmr_pkg.sv ----
/*
 Package for the power monitor result and threshold block: register codes,
 field positions, reset values, scaling constants and the carrier structs.
 Assumes nothing of its surroundings; imported by name only.
*/
package pmr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register codes on the management port
    localparam logic [7:0] ADDR_GAIN     = 8'h38;
    localparam logic [7:0] ADDR_BUS      = 8'h8B;
    localparam logic [7:0] ADDR_CUR      = 8'h8C;
    localparam logic [7:0] ADDR_TEMP     = 8'h8D;
    localparam logic [7:0] ADDR_POWER    = 8'h96;
    localparam logic [7:0] ADDR_SHUNT    = 8'hD6;
    localparam logic [7:0] ADDR_PEAK_CFG = 8'hD7;
    localparam logic [7:0] ADDR_CUR_MIN  = 8'hD8;
    localparam logic [7:0] ADDR_CUR_MAX  = 8'hD9;
    localparam logic [7:0] ADDR_LIMIT    = 8'hDA;
    localparam logic [7:0] ADDR_AUX      = 8'hE1;

    ////////////////////////////////////////////////////////////////////////
    // field positions and reset values
    localparam int PEAK_EN_BIT  = 0;
    localparam int LIM_SEL_BIT  = 9;
    localparam int LIM_RNG_MSB  = 8;
    localparam int LIM_RNG_LSB  = 6;
    localparam int LIM_CODE_MSB = 5;
    localparam int LIM_MSB      = 9;
    localparam int GAIN_MSB     = 14;

    localparam logic        PEAK_CFG_RST = 1'b0;
    localparam logic [9:0]  LIMIT_RST    = 10'h03F;
    localparam logic [14:0] GAIN_RST     = 15'h0000;
    localparam logic [15:0] RESULT_RST   = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // arithmetic scaling
    localparam int MATH_SHIFT  = 11;
    localparam int POWER_SHIFT = 32;
    // 2^32 / 40000 rounded: replaces a divide by 40000 with a multiply
    localparam logic signed [18:0] POWER_RECIP = 19'sh1A36E;

    // threshold full scale in bus counts; both variants land on the same counts
    localparam logic [15:0] FS_R0 = 16'hBB80;
    localparam logic [15:0] FS_R1 = 16'h5DC0;
    localparam logic [15:0] FS_R2 = 16'h2EE0;
    localparam logic [15:0] FS_R3 = 16'h1388;
    localparam logic [15:0] FS_R4 = 16'h0CE4;
    localparam logic [15:0] FS_R5 = 16'h09C4;
    localparam logic [6:0]  LIM_BASE_STEPS = 7'h10;
    localparam int          LIM_STEP_SHIFT = 6;

    // temperature threshold in temperature counts: base and eight-fold step
    localparam logic signed [15:0] OT_BASE       = 16'shDCD8;
    localparam logic [11:0]        OT_STEP_X8    = 12'hB27;
    localparam int                 OT_STEP_SHIFT = 3;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } pmr_req_t;

    typedef struct packed {
        logic        shunt_vld;
        logic [15:0] shunt;
        logic        bus_vld;
        logic [15:0] bus;
        logic        aux_vld;
        logic [15:0] aux;
        logic        temp_vld;
        logic [15:0] temp;
    } pmr_meas_t;

    typedef enum logic [1:0] {
        PMR_PK_OFF   = 2'b00,
        PMR_PK_ARMED = 2'b01,
        PMR_PK_TRACK = 2'b11
    } pmr_pk_state_t;

endpackage : pmr_pkg

// ---- hdl/pmr_peak_track.sv ----
/*
 Minimum and maximum tracker for the current result.
 Assumes a one-cycle sample strobe in the clock domain of the parent.
*/
`timescale 1ns/1ps
`default_nettype none
module pmr_peak_track (
    input  wire logic               clock,      // system clock
    input  wire logic               rstn,       // async reset, low
    input  wire logic               enable,     // tracking enable level
    input  wire logic               sample_vld, // new current result
    input  wire logic signed [15:0] sample,     // current result
    output logic signed [15:0]      min_r,      // smallest seen
    output logic signed [15:0]      max_r       // largest seen
);
    pmr_pkg::pmr_pk_state_t state_r;
    pmr_pkg::pmr_pk_state_t state_nxt;
    // a sample in the very cycle the enable arrives is taken, not lost
    wire logic take_first = (state_r != pmr_pkg::PMR_PK_TRACK) && sample_vld;
    wire logic take_next  = (state_r == pmr_pkg::PMR_PK_TRACK) && sample_vld;

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            pmr_pkg::PMR_PK_OFF:   if (enable && sample_vld) state_nxt = pmr_pkg::PMR_PK_TRACK;
                                   else if (enable) state_nxt = pmr_pkg::PMR_PK_ARMED;
            pmr_pkg::PMR_PK_ARMED: if (!enable) state_nxt = pmr_pkg::PMR_PK_OFF;
                                   else if (sample_vld) state_nxt = pmr_pkg::PMR_PK_TRACK;
            pmr_pkg::PMR_PK_TRACK: if (!enable) state_nxt = pmr_pkg::PMR_PK_OFF;
            default:               state_nxt = pmr_pkg::PMR_PK_OFF;
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= pmr_pkg::PMR_PK_OFF;
            min_r   <= pmr_pkg::RESULT_RST;
            max_r   <= pmr_pkg::RESULT_RST;
        end
        else
        begin
            state_r <= state_nxt;
            if (!enable)
            begin
                min_r <= pmr_pkg::RESULT_RST;
                max_r <= pmr_pkg::RESULT_RST;
            end
            else if (take_first)
            begin
                min_r <= sample;
                max_r <= sample;
            end
            else if (take_next)
            begin
                if (sample < min_r) min_r <= sample;
                if (sample > max_r) max_r <= sample;
            end
        end
    end

    peak_order_a: assert property (@(posedge clock) disable iff (!rstn)
        enable && sample_vld |=> enable |-> (min_r <= max_r) && (min_r <= $past(sample))
                                            && (max_r >= $past(sample)))
        else $error("peak registers miss a tracked sample");
endmodule : pmr_peak_track
`default_nettype wire

// ---- hdl/pmr_limit_cmp.sv ----
/*
 Real-time limit comparators: over-voltage or over-temperature through one
 multiplexed comparator, plus under-voltage and over-current.
 Assumes results and limits come from flip-flops in the parent.
*/
`timescale 1ns/1ps
`default_nettype none
module pmr_limit_cmp (
    input  wire logic               clock,      // system clock
    input  wire logic               rstn,       // async reset, low
    input  wire logic               src_sel,    // 1 compares temperature
    input  wire logic [2:0]         range_code, // full-scale range code
    input  wire logic [5:0]         limit_code, // upper limit code
    input  wire logic               is_60v,     // supply variant
    input  wire logic [15:0]        bus,        // bus voltage result
    input  wire logic signed [15:0] temp,       // temperature result
    input  wire logic signed [15:0] shunt,      // shunt voltage result
    input  wire logic [15:0]        uv_limit,   // under-voltage level, bus counts
    input  wire logic signed [15:0] oc_limit,   // over-current level, shunt counts
    output logic                    over_r,     // over-voltage/temperature
    output logic                    under_r,    // under-voltage
    output logic                    overcur_r   // over-current
);
    // codes 4 and 5 exist on the 60V variant only; elsewhere the over-voltage compare stays quiet
    wire logic        rng_ok = (range_code <= 3'h3) || (is_60v && range_code <= 3'h5);
    wire logic [15:0] fs = (range_code == 3'h0) ? pmr_pkg::FS_R0 :
                           (range_code == 3'h1) ? pmr_pkg::FS_R1 :
                           (range_code == 3'h2) ? pmr_pkg::FS_R2 :
                           (range_code == 3'h3) ? pmr_pkg::FS_R3 :
                           (range_code == 3'h4) ? pmr_pkg::FS_R4 : pmr_pkg::FS_R5;
    wire logic [22:0] v_prod = fs * (pmr_pkg::LIM_BASE_STEPS + {1'b0, limit_code});
    wire logic [15:0] v_thr  = v_prod[pmr_pkg::LIM_STEP_SHIFT +: 16];
    wire logic [17:0] t_prod = pmr_pkg::OT_STEP_X8 * limit_code;
    wire logic signed [15:0] t_thr = pmr_pkg::OT_BASE + $signed({1'b0, t_prod[17:pmr_pkg::OT_STEP_SHIFT]});
    wire logic over_nxt = src_sel ? (temp > t_thr) : (rng_ok && bus > v_thr);

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            over_r    <= 1'b0;
            under_r   <= 1'b0;
            overcur_r <= 1'b0;
        end
        else
        begin
            over_r    <= over_nxt;
            under_r   <= bus < uv_limit;
            overcur_r <= shunt > oc_limit;
        end
    end

    ot_select_a: assert property (@(posedge clock) disable iff (!rstn)
        src_sel && $stable(temp) && $stable(limit_code) && temp > t_thr |=> over_r)
        else $error("over-temperature not flagged");
    ov_scale_a: assert property (@(posedge clock) disable iff (!rstn)
        !src_sel && range_code == 3'h0 && limit_code == 6'h3F && bus > 16'hE772 |=> over_r)
        else $error("over-voltage at top code not flagged");
endmodule : pmr_limit_cmp
`default_nettype wire

// ---- hdl/pmr_monitor.sv ----
/*
 Result registers and threshold configuration of the power monitor core.
 Holds shunt, bus, auxiliary and temperature results, computes current and
 power, tracks current extremes and drives the limit comparators.
 Assumes the converter hands over results as one-cycle strobes and that the
 serial management front end presents register requests as single pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module pmr_monitor #(
    parameter logic IS_60V = 1'b1 // supply variant, enables range codes 4 and 5
) (
    input  wire logic                clock,       // 200 MHz system clock
    input  wire logic                rstn,        // async reset, low
    input  wire pmr_pkg::pmr_req_t   req,         // register request pulse
    output logic [15:0]              rdata_r,     // read data
    output logic                     ack_r,       // request answered
    output logic                     miss_r,      // request hit no register
    input  wire pmr_pkg::pmr_meas_t  meas,        // converter results
    input  wire logic [15:0]         uv_limit,    // under-voltage level
    input  wire logic signed [15:0]  oc_limit,    // over-current level
    output logic                     over_flag,   // over-voltage/temperature
    output logic                     under_flag,  // under-voltage
    output logic                     overcur_flag // over-current
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic signed [15:0] sat16(input logic signed [50:0] v);
        if (v > 51'sh7FFF)
            sat16 = 16'sh7FFF;
        else if (v < -51'sh8000)
            sat16 = 16'sh8000;
        else
            sat16 = v[15:0];
    endfunction : sat16

    ////////////////////////////////////////////////////////////////////////
    // state

    logic signed [15:0] shunt_r;
    logic [15:0]        bus_r;
    logic [15:0]        aux_r;
    logic signed [15:0] temp_r;
    logic signed [15:0] current_r;
    logic signed [15:0] power_r;
    logic               cur_vld_r;
    logic               peak_en_r;
    logic [9:0]         limit_r;
    logic [14:0]        gain_r;
    logic               gain_set_r;
    logic signed [15:0] cur_min;
    logic signed [15:0] cur_max;

    ////////////////////////////////////////////////////////////////////////
    // write decode; result addresses have no write strobe at all

    wire logic wr_peak  = req.wr && req.addr == pmr_pkg::ADDR_PEAK_CFG;
    wire logic wr_limit = req.wr && req.addr == pmr_pkg::ADDR_LIMIT;
    wire logic wr_gain  = req.wr && req.addr == pmr_pkg::ADDR_GAIN;
    wire logic ro_hit   = req.addr == pmr_pkg::ADDR_BUS || req.addr == pmr_pkg::ADDR_CUR ||
                          req.addr == pmr_pkg::ADDR_TEMP || req.addr == pmr_pkg::ADDR_POWER ||
                          req.addr == pmr_pkg::ADDR_SHUNT || req.addr == pmr_pkg::ADDR_CUR_MIN ||
                          req.addr == pmr_pkg::ADDR_CUR_MAX || req.addr == pmr_pkg::ADDR_AUX;
    wire logic rw_hit   = req.addr == pmr_pkg::ADDR_PEAK_CFG || req.addr == pmr_pkg::ADDR_LIMIT ||
                          req.addr == pmr_pkg::ADDR_GAIN;
    wire logic any_hit  = ro_hit || rw_hit;

    ////////////////////////////////////////////////////////////////////////
    // read selection; unused upper bits read as zero

    wire logic [15:0] rd_mux =
        (req.addr == pmr_pkg::ADDR_BUS)      ? bus_r :
        (req.addr == pmr_pkg::ADDR_CUR)      ? current_r :
        (req.addr == pmr_pkg::ADDR_TEMP)     ? temp_r :
        (req.addr == pmr_pkg::ADDR_POWER)    ? power_r :
        (req.addr == pmr_pkg::ADDR_SHUNT)    ? shunt_r :
        (req.addr == pmr_pkg::ADDR_PEAK_CFG) ? {15'h0000, peak_en_r} :
        (req.addr == pmr_pkg::ADDR_CUR_MIN)  ? cur_min :
        (req.addr == pmr_pkg::ADDR_CUR_MAX)  ? cur_max :
        (req.addr == pmr_pkg::ADDR_LIMIT)    ? {6'h00, limit_r} :
        (req.addr == pmr_pkg::ADDR_AUX)      ? aux_r :
        (req.addr == pmr_pkg::ADDR_GAIN)     ? {1'b0, gain_r} : 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // arithmetic: current from shunt and gain, power from current and bus

    wire logic signed [15:0] shunt_in_s = meas.shunt;
    wire logic signed [31:0] cur_prod  = shunt_in_s * $signed({1'b0, gain_r});
    wire logic signed [32:0] pw_prod   = current_r * $signed({1'b0, bus_r});
    wire logic signed [51:0] pw_scaled = pw_prod * pmr_pkg::POWER_RECIP;
    wire logic signed [50:0] cur_wide  = 51'(cur_prod >>> pmr_pkg::MATH_SHIFT);
    wire logic signed [50:0] pw_wide   = 51'(pw_scaled >>> pmr_pkg::POWER_SHIFT);
    // current exists only once a non-zero gain has been written
    wire logic cur_take = meas.shunt_vld && gain_set_r;

    ////////////////////////////////////////////////////////////////////////
    // host port

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_r <= 16'h0000;
            ack_r   <= 1'b0;
            miss_r  <= 1'b0;
        end
        else
        begin
            ack_r  <= req.wr || req.rd;
            miss_r <= (req.wr || req.rd) && !any_hit;
            if (req.rd)
                rdata_r <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            peak_en_r  <= pmr_pkg::PEAK_CFG_RST;
            limit_r    <= pmr_pkg::LIMIT_RST;
            gain_r     <= pmr_pkg::GAIN_RST;
            gain_set_r <= 1'b0;
        end
        else
        begin
            if (wr_peak)
                peak_en_r <= req.wdata[pmr_pkg::PEAK_EN_BIT];
            if (wr_limit)
                limit_r <= req.wdata[pmr_pkg::LIM_MSB:0];
            if (wr_gain)
            begin
                gain_r     <= req.wdata[pmr_pkg::GAIN_MSB:0];
                gain_set_r <= req.wdata[pmr_pkg::GAIN_MSB:0] != 15'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result registers; loaded from the converter only, never from the host

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            shunt_r   <= pmr_pkg::RESULT_RST;
            bus_r     <= pmr_pkg::RESULT_RST;
            aux_r     <= pmr_pkg::RESULT_RST;
            temp_r    <= pmr_pkg::RESULT_RST;
            current_r <= pmr_pkg::RESULT_RST;
            power_r   <= pmr_pkg::RESULT_RST;
            cur_vld_r <= 1'b0;
        end
        else
        begin
            if (meas.shunt_vld)
                shunt_r <= meas.shunt;
            if (meas.bus_vld)
                bus_r <= meas.bus;
            if (meas.aux_vld)
                aux_r <= meas.aux;
            if (meas.temp_vld)
                temp_r <= meas.temp;
            if (cur_take)
                current_r <= sat16(cur_wide);
            cur_vld_r <= cur_take;
            // power trails current by one cycle so both products stay shallow
            if (cur_vld_r)
                power_r <= sat16(pw_wide);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // extremes of the current; no mode input, so triggered and continuous
    // conversions are handled alike

    pmr_peak_track u_peak (
        .clock      (clock),
        .rstn       (rstn),
        .enable     (peak_en_r),
        .sample_vld (cur_vld_r),
        .sample     (current_r),
        .min_r      (cur_min),
        .max_r      (cur_max)
    );

    ////////////////////////////////////////////////////////////////////////
    // limit comparators

    pmr_limit_cmp u_cmp (
        .clock      (clock),
        .rstn       (rstn),
        .src_sel    (limit_r[pmr_pkg::LIM_SEL_BIT]),
        .range_code (limit_r[pmr_pkg::LIM_RNG_MSB:pmr_pkg::LIM_RNG_LSB]),
        .limit_code (limit_r[pmr_pkg::LIM_CODE_MSB:0]),
        .is_60v     (IS_60V),
        .bus        (bus_r),
        .temp       (temp_r),
        .shunt      (shunt_r),
        .uv_limit   (uv_limit),
        .oc_limit   (oc_limit),
        .over_r     (over_flag),
        .under_r    (under_flag),
        .overcur_r  (overcur_flag)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_disable_write;
        wr_peak && !req.wdata[pmr_pkg::PEAK_EN_BIT];
    endsequence

    sequence s_current_step;
        cur_take ##1 cur_vld_r;
    endsequence

    peak_enable_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_peak |=> peak_en_r == $past(req.wdata[pmr_pkg::PEAK_EN_BIT]))
        else $error("peak enable bit not stored");

    peak_clear_a: assert property (@(posedge clock) disable iff (!rstn)
        s_disable_write |-> ##2 (cur_min == 16'h0000 && cur_max == 16'h0000))
        else $error("extremes not cleared on disable");

    peak_update_a: assert property (@(posedge clock) disable iff (!rstn)
        peak_en_r && u_peak.state_r == pmr_pkg::PMR_PK_TRACK && cur_vld_r && !wr_peak
        && current_r > cur_max |=> cur_max == $past(current_r))
        else $error("maximum did not follow larger current");

    peak_only_cur_a: assert property (@(posedge clock) disable iff (!rstn)
        !cur_vld_r && peak_en_r && !wr_peak |=> $stable(cur_min) && $stable(cur_max))
        else $error("extremes changed without a current result");

    gain_gate_a: assert property (@(posedge clock) disable iff (!rstn)
        !gain_set_r && !cur_vld_r |=> $stable(current_r) && $stable(power_r))
        else $error("current computed before gain set");

    power_chain_a: assert property (@(posedge clock) disable iff (!rstn)
        s_current_step |=> power_r == sat16(51'($past(pw_scaled) >>> pmr_pkg::POWER_SHIFT)))
        else $error("power not taken after current");

    ro_write_a: assert property (@(posedge clock) disable iff (!rstn)
        req.wr && ro_hit && !meas.shunt_vld && !meas.bus_vld && !meas.aux_vld && !meas.temp_vld
        && !cur_take && !cur_vld_r && !wr_peak && !peak_en_r
        |=> $stable(current_r) && $stable(shunt_r) && $stable(bus_r) && $stable(aux_r)
            && $stable(temp_r) && $stable(power_r) && $stable(cur_min) && $stable(cur_max))
        else $error("result register changed on host write");

    temp_read_a: assert property (@(posedge clock) disable iff (!rstn)
        meas.temp_vld ##1 (req.rd && req.addr == pmr_pkg::ADDR_TEMP && !meas.temp_vld)
        |=> rdata_r == $past(meas.temp, 2) && ack_r)
        else $error("temperature read back wrong");

    limit_reset_a: assert property (@(posedge clock) disable iff (!rstn)
        req.rd && req.addr == pmr_pkg::ADDR_LIMIT && !$past(wr_limit) && limit_r == pmr_pkg::LIMIT_RST
        |=> rdata_r == 16'h003F)
        else $error("limit register reads wrong");

    // loads are held against the strobed value, not against the read mux
    shunt_load_a: assert property (@(posedge clock) disable iff (!rstn)
        meas.shunt_vld |=> shunt_r == $past(meas.shunt))
        else $error("shunt result not loaded");

    bus_load_a: assert property (@(posedge clock) disable iff (!rstn)
        meas.bus_vld |=> bus_r == $past(meas.bus))
        else $error("bus result not loaded");

    aux_load_a: assert property (@(posedge clock) disable iff (!rstn)
        meas.aux_vld |=> aux_r == $past(meas.aux))
        else $error("aux result not loaded");

    temp_load_a: assert property (@(posedge clock) disable iff (!rstn)
        meas.temp_vld |=> temp_r == $past(meas.temp))
        else $error("temperature result not loaded");

    limit_store_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_limit |=> limit_r == $past(req.wdata[pmr_pkg::LIM_MSB:0]))
        else $error("limit register not stored");

    gain_store_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_gain |=> gain_r == $past(req.wdata[pmr_pkg::GAIN_MSB:0]))
        else $error("gain register not stored");

    peak_zero_a: assert property (@(posedge clock) disable iff (!rstn)
        !peak_en_r |=> cur_min == 16'sh0000 && cur_max == 16'sh0000)
        else $error("extremes not zero while disabled");

    peak_bounds_a: assert property (@(posedge clock) disable iff (!rstn)
        cur_min <= cur_max)
        else $error("minimum above maximum");

    cfg_reserved_a: assert property (@(posedge clock) disable iff (!rstn)
        req.rd && req.addr == pmr_pkg::ADDR_PEAK_CFG |=> rdata_r[15:1] == 15'h0000)
        else $error("peak config unused bits not zero");

    ro_write_ack_a: assert property (@(posedge clock) disable iff (!rstn)
        req.wr && ro_hit |=> ack_r && !miss_r)
        else $error("result write not acknowledged");

    miss_flag_a: assert property (@(posedge clock) disable iff (!rstn)
        (req.wr || req.rd) && !any_hit |=> ack_r && miss_r)
        else $error("unmapped request not flagged");

    cur_hold_a: assert property (@(posedge clock) disable iff (!rstn)
        !cur_take |=> $stable(current_r))
        else $error("current changed without a shunt result");

    power_hold_a: assert property (@(posedge clock) disable iff (!rstn)
        !cur_vld_r |=> $stable(power_r))
        else $error("power changed without a current result");

    cur_scale_a: assert property (@(posedge clock) disable iff (!rstn)
        cur_take && gain_r == 15'h0800 |=> current_r == $past(meas.shunt))
        else $error("unity gain current wrong");

    over_rng_a: assert property (@(posedge clock) disable iff (!rstn)
        !limit_r[pmr_pkg::LIM_SEL_BIT]
        && limit_r[pmr_pkg::LIM_RNG_MSB:pmr_pkg::LIM_RNG_LSB] > (IS_60V ? 3'h5 : 3'h3) |=> !over_flag)
        else $error("over-voltage flagged on unusable range");

endmodule : pmr_monitor
`default_nettype wire

// ---- tb/pmr_host_model.sv ----
/*
 Host model of the management port: one register request per call.
 Assumes answers come one cycle after the request edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pmr_host_model (
    input  wire logic          clock,   // system clock
    output var pmr_pkg::pmr_req_t req,  // request pulse
    input  wire logic [15:0]   rdata_r, // read data
    input  wire logic          ack_r,   // answer strobe
    input  wire logic          miss_r   // no such register
);
    initial req = '0;
    task access(input logic w, input logic [7:0] a, input logic [15:0] d,
                output logic [15:0] q, output logic [1:0] ms);
        @(negedge clock);
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clock);
        // idle bus drops wr and rd and shows inverted address and data, never the last value
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        q = rdata_r;
        ms = {ack_r, miss_r};
    endtask : access
endmodule : pmr_host_model
`default_nettype wire

// ---- tb/tb_top.sv ----
/*
 Self-checking bench for the monitor result and threshold block.
 Assumes the host model in the same folder; inputs move on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    pmr_pkg::pmr_req_t req;
    pmr_pkg::pmr_meas_t meas = '0;
    logic [15:0] rdata_r;
    logic ack_r, miss_r, over_flag, under_flag, overcur_flag;
    int n_fail = 0;
    int n_tests = 0;
    always #2.5 clock = ~clock;
    pmr_host_model host (.clock(clock), .req(req), .rdata_r(rdata_r), .ack_r(ack_r), .miss_r(miss_r));
    pmr_monitor #(.IS_60V(1'b1)) uut (.clock(clock), .rstn(rstn), .req(req), .rdata_r(rdata_r),
        .ack_r(ack_r), .miss_r(miss_r), .meas(meas), .uv_limit(16'h0010), .oc_limit(16'h0064),
        .over_flag(over_flag), .under_flag(under_flag), .overcur_flag(overcur_flag));
    ////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] q;
        logic [1:0] ms;
        host.access(1'b0, a, 16'h0000, q, ms);
        chk(q, e);
        chk({14'h0000, ms}, 16'h0002);
    endtask : rd
    task wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        logic [1:0] ms;
        host.access(1'b1, a, d, q, ms);
        chk({14'h0000, ms}, 16'h0002);
        repeat (2) @(negedge clock);
    endtask : wr
    // all channels strobed together; aux carries the bus value
    task strobe(input logic [15:0] s, input logic [15:0] b, input logic [15:0] t);
        @(negedge clock);
        meas = '{1'b1, s, 1'b1, b, 1'b1, b, 1'b1, t};
        @(negedge clock);
        meas = '{1'b0, ~s, 1'b0, ~b, 1'b0, ~b, 1'b0, ~t};
        repeat (3) @(negedge clock);
    endtask : strobe
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        logic [15:0] q;
        logic [1:0] ms;
        rd(8'hD7, 16'h0000);
        rd(8'hDA, 16'h003F);
        host.access(1'b0, 8'h00, 16'h0000, q, ms);
        chk({14'h0000, ms}, 16'h0003);
        chk(under_flag, 1'b1);
    endtask : t_reset
    task t_results;
        strobe(16'h0064, 16'h9C41, 16'hDCD9);
        wr(8'hD6, 16'h1234);
        rd(8'hD6, 16'h0064);
        rd(8'h8C, 16'h0000);
        rd(8'h8B, 16'h9C41);
        rd(8'hE1, 16'h9C41);
        rd(8'h8D, 16'hDCD9);
        chk(under_flag, 1'b0);
        // read in the cycle right after the temperature strobe
        meas.temp_vld = 1'b1;
        meas.temp = 16'h1F40;
        fork
            rd(8'h8D, 16'h1F40);
            begin
                @(negedge clock);
                meas.temp_vld = 1'b0;
            end
        join
    endtask : t_results
    task t_math;
        wr(8'h38, 16'h0800);
        strobe(16'h0064, 16'h9C41, 16'hDCD9);
        rd(8'h8C, 16'h0064);
        rd(8'h96, 16'h0064);
    endtask : t_math
    task t_peak;
        wr(8'hD7, 16'h0001);
        strobe(16'hFFCE, 16'h9C41, 16'hDCD9);
        strobe(16'h00C8, 16'h9C41, 16'hDCD9);
        strobe(16'h001E, 16'h9C41, 16'hDCD9);
        rd(8'hD8, 16'hFFCE);
        rd(8'hD9, 16'h00C8);
        wr(8'hD7, 16'h0000);
        rd(8'hD8, 16'h0000);
        strobe(16'h012C, 16'h9C41, 16'hDCD9);
        rd(8'hD9, 16'h0000);
    endtask : t_peak
    task t_limit;
        // range 3, code 0: threshold 1250 bus counts
        wr(8'hDA, 16'h00C0);
        strobe(16'h00C8, 16'h04E3, 16'hDCD9);
        chk(over_flag, 1'b1);
        chk(overcur_flag, 1'b1);
        strobe(16'h00C8, 16'h04E2, 16'hDCD9);
        chk(over_flag, 1'b0);
        // temperature mode: code 0 is -9000, code 1 is -8644
        wr(8'hDA, 16'h0200);
        chk(over_flag, 1'b1);
        wr(8'hDA, 16'h0201);
        chk(over_flag, 1'b0);
        // range 4 threshold 825 counts; range 7 must stay quiet
        wr(8'hDA, 16'h0100);
        chk(over_flag, 1'b1);
        wr(8'hDA, 16'h01C0);
        chk(over_flag, 1'b0);
    endtask : t_limit
    initial
    begin
        repeat (4) @(negedge clock);
        rstn = 1'b1;
        t_reset();
        t_results();
        t_math();
        t_peak();
        t_limit();
        close_out();
    end
    initial
    begin
        #100000;
        n_fail++;
        close_out();
    end
endmodule : tb_top
`default_nettype wire
